// ---- rtl/sfc_pkg.sv ----
// Purpose: Shared constants and types for the serial flash command port
// Assumes: Serial clock is sampled by the 10 MHz core clock
// Notes: Opcodes, status layout, array geometry and dummy lengths live here
package sfc_pkg;
  // ==========================================================================
  // Array geometry
  localparam int ADDR_W = 22;
  localparam int PAGE_BITS = 8;
  localparam int SECTOR_BITS = 12;
  localparam int BLOCK_BITS = 16;
  localparam int BLOCK_IDX_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_READ = 8'heb;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_CONT_PROGRAM = 8'had;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_SIG = 8'hab;
  localparam logic [7:0] OP_STD_ID = 8'h9f;
  localparam logic [7:0] OP_MAKER_DEV_ID = 8'h90;
  localparam logic [7:0] OP_MAKER_DEV_ID_DUAL = 8'hef;
  localparam logic [7:0] OP_MAKER_DEV_ID_QUAD = 8'hdf;

  // ==========================================================================
  // Status register layout
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_SRWD = 7;
  localparam logic [3:0] BP_RESET = 4'h0;

  // ==========================================================================
  // Serial framing: counts are in bits, dummy lengths in serial clocks
  localparam logic [4:0] ADDR_BITS = 5'd24;
  localparam logic [4:0] BYTE_BITS = 5'd8;
  localparam int DUMMY_CLK_FAST = 8;
  localparam int DUMMY_CLK_QUAD = 6;
  localparam int DUMMY_CLK_DUAL = 4;
  localparam logic [4:0] DUMMY_BITS_FAST = 5'(DUMMY_CLK_FAST * 1);
  localparam logic [4:0] DUMMY_BITS_QUAD = 5'(DUMMY_CLK_QUAD * 4);
  localparam logic [4:0] DUMMY_BITS_DUAL = 5'(DUMMY_CLK_DUAL * 2);
  localparam logic [5:0] PIN_RESET = 6'h02;

  // Erase granularity
  localparam logic [1:0] ER_SECTOR = 2'h0;
  localparam logic [1:0] ER_BLOCK = 2'h1;
  localparam logic [1:0] ER_CHIP = 2'h2;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_IGNORE} sfc_phase_e;
endpackage

// ---- rtl/sfc_flash_port.sv ----
// Purpose: Device-side serial command port of a 32-Mbit serial flash
// Assumes: Pins arrive asynchronously; array sits behind plain ports
// Notes: Overview of operation follows
// Overview of operation
// - Only serial modes 0 and 3 supported
// - Fast read: 8 dummy clocks, 104MHz
// - Four-line read: 6 dummy clocks, 75MHz
// - Two-line read: 4 dummy clocks, 75MHz
// - Program by byte, 256-byte page, word
// - Erase sector, block or whole array
// - 1024 sectors, each erasable alone
// - 64 blocks, each erasable alone
// - Internal algorithm performs and verifies operations
// - Progress bit shows ongoing program or erase
// - Transfers only while chip select low
// - Standby when deselected and idle
// - Two-line read makes lines 0,1 bidirectional
// - Four-line read uses all four lines
// - Continuous program advances address itself
// - Reads continue through successive addresses
// - Four protect bits select locked region
// - Standard ID: maker then two device bytes
// - Signature command returns one device byte
// - Maker/device reads return two ID bytes
// - Line 2 is write-protect outside quad
// - Alteration needs write latch set first
// - Deep sleep ignores all but wake
// - Quad read disables hardware protect mode
`timescale 1ns/100ps

// ============================================================================
// Byte FIFO between the serial receiver and the array write port
module sfc_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign inReady = (count_r != FULL);
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // Storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers wrap explicitly so any depth works
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ============================================================================
// Command port top
module sfc_flash_port
  import sfc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3a,   // Arbitrary value
  parameter logic [7:0] DEV_ID_HI = 8'h51,  // Arbitrary value
  parameter logic [7:0] DEV_ID_LO = 8'h07,  // Arbitrary value
  parameter logic [7:0] SIG_ID = 8'h29,     // Arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csN,
  input wire logic ioLine0In,
  output logic ioLine0Out,
  output logic ioLine0Oe,
  input wire logic ioLine1In,
  output logic ioLine1Out,
  output logic ioLine1Oe,
  input wire logic ioLine2In,
  output logic ioLine2Out,
  output logic ioLine2Oe,
  input wire logic ioLine3In,
  output logic ioLine3Out,
  output logic ioLine3Oe,
  output logic [ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output logic memWrValid,
  input wire logic memWrReady,
  output logic [ADDR_W-1:0] memWrAddr,
  output logic [7:0] memWrData,
  output logic eraseReq,
  output logic [1:0] eraseKind,
  output logic [ADDR_W-1:0] eraseAddr,
  input wire logic eraseDone,
  output logic writeInProgress,
  output logic standby,
  output logic deepSleep
);
  // ==========================================================================
  // Pin synchronisers: {io3, io2, io1, io0, csN, sclk}
  logic [5:0] pinMeta_r;
  logic [5:0] pinSync_r;
  logic sclkPrev_r;
  logic csPrev_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pinMeta_r <= PIN_RESET;
      pinSync_r <= PIN_RESET;
      sclkPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
    end else begin
      pinMeta_r <= {ioLine3In, ioLine2In, ioLine1In, ioLine0In, csN, sclk};
      pinSync_r <= pinMeta_r;
      sclkPrev_r <= pinSync_r[0];
      csPrev_r <= pinSync_r[1];
    end
  end

  logic csHigh;
  logic csRise;
  logic sclkRise;
  logic sclkFall;
  logic [3:0] inBits;
  // Sample on rise, drive on fall: fits both idle levels of the clock
  assign csHigh = pinSync_r[1];
  assign csRise = csHigh & ~csPrev_r;
  assign sclkRise = pinSync_r[0] & ~sclkPrev_r & ~csHigh;
  assign sclkFall = ~pinSync_r[0] & sclkPrev_r & ~csHigh;
  assign inBits = pinSync_r[5:2];

  // ==========================================================================
  // Decoding helpers
  function automatic logic isProtected(input logic [3:0] bp, input logic [5:0] blk);
    logic [6:0] lim;
    lim = 7'd0;
    isProtected = 1'b0;
    if (bp >= 4'd1 && bp <= 4'd6) begin
      lim = 7'd64 - (7'd1 << (bp - 4'd1));
      isProtected = ({1'b0, blk} >= lim);
    end else if (bp >= 4'd9 && bp <= 4'd14) begin
      lim = 7'd64 - (7'd1 << (4'd14 - bp));
      isProtected = ({1'b0, blk} < lim);
    end else if (bp != 4'd0) begin
      isProtected = 1'b1;
    end
  endfunction

  function automatic sfc_phase_e phaseAfterCmd(input logic [7:0] op, input logic cp);
    case (op)
      OP_READ, OP_FAST_READ, OP_DUAL_READ, OP_QUAD_READ, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
      OP_PAGE_PROGRAM, OP_WAKE_SIG, OP_MAKER_DEV_ID, OP_MAKER_DEV_ID_DUAL,
      OP_MAKER_DEV_ID_QUAD: phaseAfterCmd = PH_ADDR;
      OP_READ_STATUS, OP_STD_ID: phaseAfterCmd = PH_DOUT;
      OP_WRITE_STATUS: phaseAfterCmd = PH_DIN;
      OP_CONT_PROGRAM: phaseAfterCmd = cp ? PH_DIN : PH_ADDR;
      default: phaseAfterCmd = PH_IGNORE;
    endcase
  endfunction

  function automatic sfc_phase_e phaseAfterAddr(input logic [7:0] op);
    case (op)
      OP_FAST_READ, OP_DUAL_READ, OP_QUAD_READ: phaseAfterAddr = PH_DUMMY;
      OP_PAGE_PROGRAM, OP_CONT_PROGRAM: phaseAfterAddr = PH_DIN;
      OP_SECTOR_ERASE, OP_BLOCK_ERASE: phaseAfterAddr = PH_IGNORE;
      default: phaseAfterAddr = PH_DOUT;
    endcase
  endfunction

  // ==========================================================================
  // Shared state declarations
  sfc_phase_e phase_r;
  logic [7:0] cmd_r;
  logic [4:0] cnt_r;
  logic [2:0] tot_r;
  logic [2:0] lanes_r;
  logic [23:0] shIn_r;
  logic [ADDR_W-1:0] addr_r;
  logic addrDone_r;
  logic dinSeen_r;
  logic [7:0] wrsrData_r;
  logic wel_r;
  logic [3:0] bp_r;
  logic srwd_r;
  logic sleep_r;
  logic cpMode_r;
  logic quad_r;
  logic progBusy_r;
  logic eraseBusy_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic pushValid_r;
  logic [7:0] pushData_r;
  logic [23:0] shNext;
  logic [4:0] cntNext;
  logic [4:0] dummyBits;
  logic write_in_progress;
  logic addrDoneNow;
  logic byteDoneDin;
  logic [7:0] statusByte;

  assign write_in_progress = progBusy_r | eraseBusy_r;
  assign cntNext = cnt_r + {2'b00, lanes_r};
  assign addrDoneNow = sclkRise && phase_r == PH_ADDR && cntNext == ADDR_BITS;
  assign byteDoneDin = sclkRise && phase_r == PH_DIN && cntNext == BYTE_BITS;
  assign statusByte = {srwd_r, 1'b0, bp_r, wel_r, write_in_progress};

  // Shift in MSB first on as many lines as the mode uses
  always_comb begin
    case (lanes_r)
      3'd1: shNext = {shIn_r[22:0], inBits[0]};
      3'd2: shNext = {shIn_r[21:0], inBits[1:0]};
      default: shNext = {shIn_r[19:0], inBits};
    endcase
    case (cmd_r)
      OP_QUAD_READ: dummyBits = DUMMY_BITS_QUAD;
      OP_DUAL_READ: dummyBits = DUMMY_BITS_DUAL;
      default: dummyBits = DUMMY_BITS_FAST;
    endcase
  end

  // ==========================================================================
  // Receive sequencer; deselect returns it to the opcode phase
  always_ff @(posedge mclk) begin
    if (reset || csHigh) begin
      phase_r <= PH_CMD;
      cmd_r <= 8'h00;
      cnt_r <= 5'd0;
      tot_r <= 3'd0;
      lanes_r <= 3'd1;
      shIn_r <= 24'h000000;
      addr_r <= ADDR_RESET;
      addrDone_r <= 1'b0;
      dinSeen_r <= 1'b0;
    end else if (sclkRise) begin
      shIn_r <= shNext;
      cnt_r <= cntNext;
      tot_r <= tot_r + lanes_r;  // Bits mod 8 for byte-boundary check
      case (phase_r)
        PH_CMD: begin
          if (cntNext == BYTE_BITS) begin
            cnt_r <= 5'd0;
            // Refused opcodes keep no code, so nothing acts at deselect
            if (sleep_r && shNext[7:0] != OP_WAKE_SIG) begin
              phase_r <= PH_IGNORE;
              cmd_r <= 8'h00;
            end else if (write_in_progress && shNext[7:0] != OP_READ_STATUS) begin
              phase_r <= PH_IGNORE;  // Busy array takes status polls only
              cmd_r <= 8'h00;
            end else begin
              phase_r <= phaseAfterCmd(shNext[7:0], cpMode_r);
              cmd_r <= shNext[7:0];
            end
            if (shNext[7:0] == OP_DUAL_READ) begin
              lanes_r <= 3'd2;
            end else if (shNext[7:0] == OP_QUAD_READ) begin
              lanes_r <= 3'd4;
            end
          end
        end
        PH_ADDR: begin
          if (cntNext == ADDR_BITS) begin
            addr_r <= shNext[ADDR_W-1:0];
            addrDone_r <= 1'b1;
            cnt_r <= 5'd0;
            phase_r <= phaseAfterAddr(cmd_r);
          end
        end
        PH_DUMMY: begin
          if (cntNext == dummyBits) begin
            cnt_r <= 5'd0;
            phase_r <= PH_DOUT;
          end
        end
        PH_DIN: begin
          if (cntNext == BYTE_BITS) begin
            cnt_r <= 5'd0;
            dinSeen_r <= 1'b1;
          end
        end
        default: cnt_r <= 5'd0;
      endcase
    end
  end

  // ==========================================================================
  // Transmit path: next byte source, then lanes driven on falling edges
  logic [7:0] outSh_r;
  logic [2:0] outPos_r;
  logic [1:0] idIdx_r;
  logic [7:0] nextByte;
  logic [7:0] curByte;

  always_comb begin
    case (cmd_r)
      OP_READ_STATUS: nextByte = statusByte;
      OP_STD_ID: begin
        case (idIdx_r)
          2'd0: nextByte = MAKER_ID;
          2'd1: nextByte = DEV_ID_HI;
          default: nextByte = DEV_ID_LO;
        endcase
      end
      OP_WAKE_SIG: nextByte = SIG_ID;
      OP_MAKER_DEV_ID, OP_MAKER_DEV_ID_DUAL, OP_MAKER_DEV_ID_QUAD:
        nextByte = (idIdx_r[0] ^ addr_r[0]) ? SIG_ID : MAKER_ID;
      default: nextByte = memRdData;
    endcase
    curByte = (outPos_r == 3'd0) ? nextByte : outSh_r;
  end

  always_ff @(posedge mclk) begin
    if (reset || csHigh) begin
      {ioLine3Oe, ioLine2Oe, ioLine1Oe, ioLine0Oe} <= 4'h0;
      {ioLine3Out, ioLine2Out, ioLine1Out, ioLine0Out} <= 4'h0;
      outSh_r <= 8'h00;
      outPos_r <= 3'd0;
      idIdx_r <= 2'd0;
    end else if (sclkFall && phase_r == PH_DOUT) begin
      outPos_r <= outPos_r + lanes_r;
      case (lanes_r)
        3'd1: begin
          ioLine1Out <= curByte[7];
          ioLine1Oe <= 1'b1;
          outSh_r <= {curByte[6:0], 1'b0};
        end
        3'd2: begin
          {ioLine1Out, ioLine0Out} <= curByte[7:6];
          {ioLine1Oe, ioLine0Oe} <= 2'h3;
          outSh_r <= {curByte[5:0], 2'h0};
        end
        default: begin
          {ioLine3Out, ioLine2Out, ioLine1Out, ioLine0Out} <= curByte[7:4];
          {ioLine3Oe, ioLine2Oe, ioLine1Oe, ioLine0Oe} <= 4'hf;
          outSh_r <= {curByte[3:0], 4'h0};
        end
      endcase
      if (outPos_r == 3'd0) begin
        idIdx_r <= (cmd_r == OP_STD_ID && idIdx_r == 2'd2) ? 2'd0 : idIdx_r + 2'd1;
      end
    end
  end

  // Read pointer: loaded from the address, bumped as each byte is taken
  always_ff @(posedge mclk) begin
    if (reset) begin
      memRdAddr <= ADDR_RESET;
    end else if (addrDoneNow) begin
      memRdAddr <= shNext[ADDR_W-1:0];
    end else if (sclkFall && phase_r == PH_DOUT && outPos_r == 3'd0) begin
      memRdAddr <= memRdAddr + 1'b1;  // Wraps at top of array
    end
  end

  // ==========================================================================
  // Program data path; only whole bytes reach the FIFO
  logic fifoInReady;
  logic [7:0] fifoOutData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic pgmOk;

  assign pgmOk = wel_r && !isProtected(bp_r, wrAddr_r[ADDR_W-1:BLOCK_BITS]);
  assign fifoOutReady = !memWrValid || memWrReady;

  // Held byte stalls until the FIFO has room; a newer byte replaces it
  always_ff @(posedge mclk) begin
    if (reset) begin
      pushValid_r <= 1'b0;
      pushData_r <= 8'h00;
      wrsrData_r <= 8'h00;
    end else begin
      if (byteDoneDin && cmd_r != OP_WRITE_STATUS && pgmOk) begin
        pushValid_r <= 1'b1;
        pushData_r <= shNext[7:0];
      end else if (fifoInReady) begin
        pushValid_r <= 1'b0;
      end
      if (byteDoneDin && cmd_r == OP_WRITE_STATUS) begin
        wrsrData_r <= shNext[7:0];
      end
    end
  end

  sfc_byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .reset(reset),
    .inData(pushData_r),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // Array write port; page program wraps inside its page, word mode runs on
  always_ff @(posedge mclk) begin
    if (reset) begin
      wrAddr_r <= ADDR_RESET;
      memWrValid <= 1'b0;
      memWrAddr <= ADDR_RESET;
      memWrData <= 8'h00;
    end else begin
      if (addrDoneNow && (cmd_r == OP_PAGE_PROGRAM || cmd_r == OP_CONT_PROGRAM)) begin
        wrAddr_r <= shNext[ADDR_W-1:0];
      end else if (fifoOutValid && fifoOutReady) begin
        if (cmd_r == OP_CONT_PROGRAM || cpMode_r) begin
          wrAddr_r <= wrAddr_r + 1'b1;
        end else begin
          wrAddr_r[PAGE_BITS-1:0] <= wrAddr_r[PAGE_BITS-1:0] + 1'b1;
        end
      end
      if (fifoOutValid && fifoOutReady) begin
        memWrValid <= 1'b1;
        memWrAddr <= wrAddr_r;
        memWrData <= fifoOutData;
      end else if (memWrReady) begin
        memWrValid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Command completion at deselect; a partial last byte cancels it
  logic cmdOk;
  logic hpmLock;
  assign cmdOk = csRise && tot_r == 3'd0 && phase_r != PH_CMD;
  assign hpmLock = srwd_r && !pinSync_r[4] && !quad_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wel_r <= 1'b0;
      bp_r <= BP_RESET;
      srwd_r <= 1'b0;
      sleep_r <= 1'b0;
      cpMode_r <= 1'b0;
      quad_r <= 1'b0;
      progBusy_r <= 1'b0;
      eraseBusy_r <= 1'b0;
      eraseReq <= 1'b0;
      eraseKind <= ER_SECTOR;
      eraseAddr <= ADDR_RESET;
    end else begin
      eraseReq <= 1'b0;
      // Done once every byte has been handed to the array
      if (progBusy_r && !fifoOutValid && !pushValid_r && !memWrValid) begin
        progBusy_r <= 1'b0;
      end
      if (eraseBusy_r && eraseDone) begin
        eraseBusy_r <= 1'b0;
      end
      if (cmdOk) begin
        case (cmd_r)
          OP_WRITE_UNLOCK: wel_r <= 1'b1;
          OP_WRITE_LOCK: begin
            wel_r <= 1'b0;
            cpMode_r <= 1'b0;
          end
          OP_WRITE_STATUS: begin
            if (wel_r && dinSeen_r && !hpmLock) begin
              bp_r <= wrsrData_r[SR_BP_LSB+3:SR_BP_LSB];
              srwd_r <= wrsrData_r[SR_SRWD];
              wel_r <= 1'b0;
            end
          end
          OP_PAGE_PROGRAM, OP_CONT_PROGRAM: begin
            if (pgmOk && dinSeen_r) begin
              progBusy_r <= 1'b1;
              if (cmd_r == OP_CONT_PROGRAM) begin
                cpMode_r <= 1'b1;  // Latch stays set until word mode ends
              end else begin
                wel_r <= 1'b0;
              end
            end
          end
          OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
            if (wel_r && addrDone_r && !isProtected(bp_r, addr_r[ADDR_W-1:BLOCK_BITS])) begin
              eraseReq <= 1'b1;
              eraseKind <= (cmd_r == OP_SECTOR_ERASE) ? ER_SECTOR : ER_BLOCK;
              eraseAddr <= (cmd_r == OP_SECTOR_ERASE) ?
                {addr_r[ADDR_W-1:SECTOR_BITS], SECTOR_BITS'(0)} :
                {addr_r[ADDR_W-1:BLOCK_BITS], BLOCK_BITS'(0)};
              eraseBusy_r <= 1'b1;
              wel_r <= 1'b0;
            end
          end
          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
            if (wel_r && bp_r == BP_RESET) begin
              eraseReq <= 1'b1;
              eraseKind <= ER_CHIP;
              eraseAddr <= ADDR_RESET;
              eraseBusy_r <= 1'b1;
              wel_r <= 1'b0;
            end
          end
          OP_DEEP_SLEEP: sleep_r <= 1'b1;
          OP_WAKE_SIG: sleep_r <= 1'b0;
          OP_QUAD_READ: quad_r <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Status pins; the progress flag lags the busy flops by one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      writeInProgress <= 1'b0;
      standby <= 1'b0;
      deepSleep <= 1'b0;
    end else begin
      writeInProgress <= write_in_progress;
      standby <= csHigh && !write_in_progress;
      deepSleep <= sleep_r;
    end
  end
endmodule

// ---- sim/sfc_host_model.sv ----
// Purpose: Host serial controller model for the command port
// Assumes: Mode 0, whole bytes, link clock 800 ns
// Notes: Undriven line1 reads back as the inverse of its last level
`timescale 1ns/100ps
module sfc_host_model (
  input wire logic mclk,
  input wire logic ioLine1Oe,
  input wire logic ioLine1Out,
  output logic sclk,
  output logic csN,
  output logic hostLine0
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostLine0 = 1'b0;
  end
  // ==========================================================================
  // One frame: clock idles low, bytes MSB first
  task automatic frame(input logic [63:0] tx, input int nTx, input int nRx,
                       output logic [31:0] rx);
    rx = 32'h0;
    csN <= 1'b0;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 8 * (nTx + nRx); i++) begin
      // Toggle line0 after the sent bytes so stale bits never look valid
      hostLine0 <= (i < 8 * nTx) ? tx[63 - i] : ~hostLine0;
      sclk <= 1'b0;
      repeat (4) @(negedge mclk);
      sclk <= 1'b1;
      repeat (4) @(negedge mclk);
      rx = {rx[30:0], ioLine1Oe ? ioLine1Out : ~rx[0]};
    end
    sclk <= 1'b0;
    repeat (4) @(negedge mclk);
    csN <= 1'b1;
    repeat (8) @(negedge mclk);
  endtask
endmodule

// ---- sim/sfc_flash_port_asserts.sv ----
// Purpose: Pin-level checks of the command port
// Assumes: One mclk domain, synchronous reset
// Notes: Bound from the bench top
`timescale 1ns/100ps
module sfc_flash_port_asserts
  import sfc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic csN,
  input wire logic ioLine0Oe,
  input wire logic ioLine1Oe,
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic [ADDR_W-1:0] memWrAddr,
  input wire logic [7:0] memWrData,
  input wire logic eraseReq,
  input wire logic [1:0] eraseKind,
  input wire logic [ADDR_W-1:0] eraseAddr,
  input wire logic writeInProgress,
  input wire logic standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Select sequences, long enough to cover the synchroniser lag
  sequence deselected; csN [*6]; endsequence
  sequence selected; !csN [*4]; endsequence
  chk_oe_release: assert property (deselected |-> !ioLine1Oe)
    else $error("line1 driven while deselected");
  chk_standby_sel: assert property (selected |-> !standby)
    else $error("standby while selected");
  chk_erase_pulse: assert property (eraseReq |=> !eraseReq)
    else $error("erase request longer than one cycle");
  chk_sector_base: assert property (eraseReq && eraseKind == ER_SECTOR |->
    eraseAddr[11:0] == 12'h000)
    else $error("sector erase base not aligned");
  chk_block_base: assert property (eraseReq && eraseKind == ER_BLOCK |->
    eraseAddr[15:0] == 16'h0000)
    else $error("block erase base not aligned");
  chk_erase_busy: assert property (eraseReq |-> ##[0:3] writeInProgress)
    else $error("erase not shown as busy");
  chk_wr_hold: assert property (memWrValid && !memWrReady |=> memWrValid &&
    $stable(memWrAddr) && $stable(memWrData))
    else $error("array write changed while stalled");
  chk_dual_pair: assert property (ioLine0Oe |-> ioLine1Oe)
    else $error("line0 driven without line1");
endmodule

// ---- sim/sfc_flash_port_tb.sv ----
// Purpose: Self-checking bench of the command port
// Assumes: Array model answers combinationally
// Notes: Identity values are the design defaults, all arbitrary
`timescale 1ns/100ps
module sfc_flash_port_tb
  import sfc_pkg::*;
;
  logic mclk, reset, sclk, csN, hostLine0, memWrReady, eraseDone, memWrValid, eraseReq;
  logic ioLine0Out, ioLine0Oe, ioLine1Out, ioLine1Oe, ioLine2Out, ioLine2Oe;
  logic ioLine3Out, ioLine3Oe, writeInProgress, standby, deepSleep;
  logic [ADDR_W-1:0] memRdAddr, memWrAddr, eraseAddr;
  logic [7:0] memRdData, memWrData;
  logic [1:0] eraseKind;
  logic [31:0] rx;
  logic [29:0] wrLog[$];
  logic [23:0] erLog[$];
  int errors = 0;
  int testsRun = 0;
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  // Array content is a fixed pattern of the address
  assign memRdData = memRdAddr[7:0] ^ 8'h5a;
  sfc_flash_port sfc_flash_port_inst (.mclk, .reset, .sclk, .csN,
    .ioLine0In(ioLine0Oe ? ioLine0Out : hostLine0), .ioLine0Out, .ioLine0Oe,
    .ioLine1In(ioLine1Oe ? ioLine1Out : ~ioLine1Out), .ioLine1Out, .ioLine1Oe,
    .ioLine2In(ioLine2Oe ? ioLine2Out : 1'b1), .ioLine2Out, .ioLine2Oe,
    .ioLine3In(ioLine3Oe ? ioLine3Out : 1'b1), .ioLine3Out, .ioLine3Oe,
    .memRdAddr, .memRdData, .memWrValid, .memWrReady, .memWrAddr, .memWrData,
    .eraseReq, .eraseKind, .eraseAddr, .eraseDone, .writeInProgress, .standby, .deepSleep);
  sfc_host_model sfc_host_model_inst (.mclk, .ioLine1Oe, .ioLine1Out, .sclk, .csN, .hostLine0);
  // Log array traffic; erase ends one cycle after busy shows
  always @(posedge mclk) begin
    if (memWrValid && memWrReady) wrLog.push_back({memWrAddr, memWrData});
    if (eraseReq) erLog.push_back({eraseKind, eraseAddr});
    eraseDone <= writeInProgress;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [63:0] tx, input int nTx, input int nRx);
    sfc_host_model_inst.frame(tx, nTx, nRx, rx);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 500 && writeInProgress !== 1'b0; i++) @(negedge mclk);
  endtask
  task automatic test_ids();
    send({OP_STD_ID, 56'h0}, 1, 3);
    check(rx[23:0], 24'h3a5107);
    send({OP_DEEP_SLEEP, 56'h0}, 1, 0);
    send({OP_WRITE_UNLOCK, 56'h0}, 1, 0);
    check(deepSleep, 1'b1);
    send({OP_WAKE_SIG, 56'h0}, 4, 1);
    check(rx[7:0], 8'h29);
    check(deepSleep, 1'b0);
    send({OP_MAKER_DEV_ID, 56'h0}, 4, 2);
    check(rx[15:0], 16'h3a29);
    $display("test ids done");
  endtask
  task automatic test_read();
    send({OP_READ, 24'h00fffe, 32'h0}, 4, 2);
    check(rx[15:0], {8'hfe ^ 8'h5a, 8'hff ^ 8'h5a});
    send({OP_FAST_READ, 24'h000010, 32'h0}, 5, 1);
    check(rx[7:0], 8'h10 ^ 8'h5a);
    $display("test read done");
  endtask
  task automatic test_program();
    send({OP_PAGE_PROGRAM, 24'h0012ff, 32'ha1000000}, 5, 0);
    check(wrLog.size(), 0);
    send({OP_WRITE_UNLOCK, 56'h0}, 1, 0);
    send({OP_READ_STATUS, 56'h0}, 1, 1);
    check(rx[7:0], 8'h02);
    // Stall the array so the write port holds the first byte and the FIFO the second
    memWrReady <= 1'b0;
    send({OP_PAGE_PROGRAM, 24'h0012ff, 32'ha1b20000}, 6, 0);
    send({OP_READ_STATUS, 56'h0}, 1, 1);
    check(rx[0], 1'b1);
    memWrReady <= 1'b1;
    wait_idle();
    check(wrLog.size(), 2);
    check(wrLog[0], {22'h0012ff, 8'ha1});
    check(wrLog[1], {22'h001200, 8'hb2});
    send({OP_READ_STATUS, 56'h0}, 1, 1);
    check(rx[7:0], 8'h00);
    $display("test program done");
  endtask
  task automatic test_erase();
    send({OP_WRITE_UNLOCK, 56'h0}, 1, 0);
    send({OP_SECTOR_ERASE, 24'h123456, 32'h0}, 4, 0);
    wait_idle();
    send({OP_WRITE_UNLOCK, 56'h0}, 1, 0);
    send({OP_BLOCK_ERASE, 24'h123456, 32'h0}, 4, 0);
    wait_idle();
    check(erLog.size(), 2);
    check(erLog[0], {ER_SECTOR, 22'h123000});
    check(erLog[1], {ER_BLOCK, 22'h120000});
    $display("test erase done");
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    memWrReady = 1'b1;
    repeat (3) @(negedge mclk);
    reset <= 1'b0;
    repeat (4) @(negedge mclk);
    test_ids();
    test_read();
    test_program();
    test_erase();
    complete_run();
  end
  // Watchdog: the tests need about 4000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
bind sfc_flash_port sfc_flash_port_asserts sfc_flash_port_asserts_inst (.mclk, .reset, .csN,
  .ioLine0Oe, .ioLine1Oe, .memWrValid, .memWrReady, .memWrAddr, .memWrData, .eraseReq,
  .eraseKind, .eraseAddr, .writeInProgress, .standby);
